// ---- verilog/frmx_cfg.svh ----
`ifndef FRMX_CFG_SVH
`define FRMX_CFG_SVH

// Opcode field, instruction bits [13:8]; load_immediate matches [13:10]
`define FRMX_OP_INC 6'h0a
`define FRMX_OP_IOR 6'h04
`define FRMX_OP_MOVE 6'h08
`define FRMX_OP_STORE 6'h00
`define FRMX_OP_LIT_HI 4'h3
`define FRMX_OP_LOC_GRP 2'h0
`define FRMX_OP_MSB 13
`define FRMX_OP_LSB 8
`define FRMX_GRP_LSB 12
`define FRMX_LIT_LSB 10
`define FRMX_ADDR_MSB 6
`define FRMX_IMM_MSB 7
`define FRMX_ZERO 8'h00
`define FRMX_TGT_BIT 7
`define FRMX_W_RESET 8'h00
`define FRMX_Z_RESET 1'b0
`define FRMX_ONE 8'h01

`endif

// ---- verilog/frmx_pkg.sv ----
package frmx_pkg;
  typedef enum logic [2:0] {
    FRMX_NOP,
    FRMX_INC,
    FRMX_IOR,
    FRMX_MOVE,
    FRMX_STORE,
    FRMX_LIT
  } frmx_op_t;

  // One instruction as issued to the datapath
  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } frmx_instr_t;

  // Write request towards data memory
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } frmx_mem_wr_t;
endpackage : frmx_pkg

// ---- verilog/frmx_exec.sv ----
`timescale 1ns/1ps
`include "frmx_cfg.svh"

// What this block does
// - Increment location, result to chosen target
// - Target bit 0 to accumulator, 1 to location
// - OR accumulator with location, to target
// - Move location unchanged to chosen target
// - Move updates zero flag even writing back
// - Store accumulator to location, flags untouched
// - Load 8-bit immediate into accumulator, no flags
// - Unused immediate encoding bits are ignored
module frmx_exec (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Instruction issue, one per enabled cycle
  input wire frmx_pkg::frmx_instr_t instr,
  // Data memory read of the addressed location
  input wire logic [7:0] mem_rdata,
  // Results
  output frmx_pkg::frmx_mem_wr_t mem_wr,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic done
);
  import frmx_pkg::*;

  // Decoded view of the word on the issue port
  frmx_op_t op;
  logic tgt;
  logic [6:0] addr;
  logic [7:0] imm;
  logic [7:0] result;
  logic wr_acc;
  logic wr_mem;
  logic upd_z;

  // Opcode field of a word
  function automatic logic [5:0] op_field(input logic [13:0] w);
    return w[`FRMX_OP_MSB:`FRMX_OP_LSB];
  endfunction : op_field

  // Load immediate owns a sixteenth of the opcode map
  function automatic logic is_lit(input logic [13:0] w);
    return w[`FRMX_OP_MSB:`FRMX_LIT_LSB] == `FRMX_OP_LIT_HI;
  endfunction : is_lit

  // Location group shares the two top opcode bits
  function automatic logic is_loc(input logic [13:0] w);
    return w[`FRMX_OP_MSB:`FRMX_GRP_LSB] == `FRMX_OP_LOC_GRP;
  endfunction : is_loc

  // Unknown words fall through to no-operation, never to a write
  function automatic frmx_op_t decode(input logic [13:0] w);
    frmx_op_t o;
    o = FRMX_NOP;
    if (is_lit(w)) begin
      // Bits between opcode and immediate carry no meaning
      o = FRMX_LIT;
    end else if (is_loc(w)) begin
      case (op_field(w))
        `FRMX_OP_INC: begin
          o = FRMX_INC;
        end
        `FRMX_OP_IOR: begin
          o = FRMX_IOR;
        end
        `FRMX_OP_MOVE: begin
          o = FRMX_MOVE;
        end
        // Store with a clear target bit is left as a no-operation
        `FRMX_OP_STORE: begin
          o = w[`FRMX_TGT_BIT] ? FRMX_STORE : FRMX_NOP;
        end
        default: begin
          o = FRMX_NOP;
        end
      endcase
    end
    return o;
  endfunction : decode

  // Zero test shared by every flag-affecting instruction
  function automatic logic is_zero(input logic [7:0] v);
    return v == `FRMX_ZERO;
  endfunction : is_zero

  assign op = instr.valid ? decode(instr.word) : FRMX_NOP;
  assign tgt = instr.word[`FRMX_TGT_BIT];
  assign addr = instr.word[`FRMX_ADDR_MSB:0];
  assign imm = instr.word[`FRMX_IMM_MSB:0];

  // Value that the instruction produces
  always_comb begin
    result = acc;
    case (op)
      FRMX_INC: begin
        // Wraps from the top value to zero, no carry kept
        result = mem_rdata + `FRMX_ONE;
      end
      FRMX_IOR: begin
        result = acc | mem_rdata;
      end
      FRMX_MOVE: begin
        result = mem_rdata;
      end
      FRMX_STORE: begin
        result = acc;
      end
      FRMX_LIT: begin
        result = imm;
      end
      default: begin
        result = acc;
      end
    endcase
  end

  // Where the value goes and whether the flag follows it
  always_comb begin
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    case (op)
      FRMX_INC, FRMX_IOR: begin
        wr_acc = !tgt;
        wr_mem = tgt;
        upd_z = 1'b1;
      end
      FRMX_MOVE: begin
        wr_acc = !tgt;
        wr_mem = tgt;
        // Write back of the same byte still sets the flag
        upd_z = 1'b1;
      end
      FRMX_STORE: begin
        wr_mem = 1'b1;
      end
      FRMX_LIT: begin
        wr_acc = 1'b1;
      end
      default: begin
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        upd_z = 1'b0;
      end
    endcase
  end

  // Accumulator
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc <= `FRMX_W_RESET;
    end else if (clk_en && wr_acc) begin
      acc <= result;
    end
  end

  // Zero flag, untouched unless the instruction affects it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      zero_flag <= `FRMX_Z_RESET;
    end else if (clk_en && upd_z) begin
      zero_flag <= is_zero(result);
    end
  end

  // Registered write keeps the memory port glitch free
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_wr.wr <= 1'b0;
    end else if (clk_en) begin
      mem_wr.wr <= wr_mem;
    end
  end

  // Address and data follow every enabled edge; only wr qualifies them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_wr.addr <= '0;
    end else if (clk_en) begin
      mem_wr.addr <= addr;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_wr.data <= '0;
    end else if (clk_en) begin
      mem_wr.data <= result;
    end
  end

  // One pulse per executed word, also for a no-operation
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
    end else if (clk_en) begin
      done <= instr.valid;
    end
  end
endmodule : frmx_exec

// ---- testbench/frmx_exec_monitor.sv ----
`timescale 1ns/1ps
module frmx_monitor (
  // Watched ports
  input logic core_clk,nrst,clk_en,zero_flag,done,
  input frmx_pkg::frmx_instr_t instr,
  input logic [7:0] mem_rdata,acc,
  input frmx_pkg::frmx_mem_wr_t mem_wr
);
  import frmx_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire t=clk_en&&instr.valid;
  // Opcode with target bit
  wire [6:0] o=instr.word[13:7];
  a_inc_mem: assert property (t&&o==7'h15|=>
    mem_wr.wr&&mem_wr.data==$past(mem_rdata)+8'h01) else $error("inc");
  a_inc_acc: assert property (t&&o==7'h14|=>
    !mem_wr.wr&&acc==$past(mem_rdata)+8'h01) else $error("inc");
  a_or_acc: assert property (t&&o==7'h08|=>
    acc==($past(acc)|$past(mem_rdata))) else $error("or");
  a_move_acc: assert property (t&&o==7'h10|=>
    acc==$past(mem_rdata)) else $error("move");
  a_move_zero: assert property (t&&o[6:1]==6'h08|=>
    zero_flag==($past(mem_rdata)==8'h00)) else $error("zero");
  a_store_keep: assert property (t&&o==7'h01|=>
    mem_wr.data==$past(acc)&&$stable(acc)&&$stable(zero_flag)) else $error("st");
  a_load_imm: assert property (t&&instr.word[13:10]==4'h3|=>
    acc==$past(instr.word[7:0])&&$stable(zero_flag)) else $error("imm");
  a_nop_still: assert property (t&&o==7'h00|=>
    done&&!mem_wr.wr&&$stable(acc)&&$stable(zero_flag)) else $error("nop");
  cover property (t&&o==7'h15);
  cover property (t&&o==7'h01);
  cover property (instr.valid&&!clk_en);
endmodule : frmx_monitor
bind frmx_exec frmx_monitor mon (.*);

// ---- testbench/file_register_move_inc_or_exec_test.sv ----
`timescale 1ns/1ps
module file_register_move_inc_or_exec_test;
  import frmx_pkg::*;
  logic core_clk=1'b0,nrst=1'b0,clk_en=1'b0,zero_flag,done;
  frmx_instr_t instr='0;
  logic [7:0] mem_rdata=8'h00,acc;
  frmx_mem_wr_t mem_wr;
  int err_count=0,cmp_count=0,cyc=0;
  logic [18:0] got;
  frmx_exec dut (.*);
  always #20 core_clk=~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc>60) begin
      err_count++;
      conclude();
    end
  end
  task conclude;
    $display("%0d compared, %0d wrong",cmp_count,err_count);
    if (err_count==0&&cmp_count>0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // Valid dropped after the edge, else the word would run twice
  task run(input logic [13:0] w,input logic [7:0] r,input logic e,
    input logic [18:0] x);
    @(posedge core_clk);
    instr<={1'b1,w};
    mem_rdata<=r;
    clk_en<=e;
    @(posedge core_clk);
    instr.valid<=1'b0;
    #1 got={mem_wr.wr,mem_wr.wr?mem_wr.data:8'h00,acc,zero_flag,done};
    cmp_count++;
    if (got!==x) begin
      err_count++;
      $display("wrong value at %0t: %h",$time,got);
    end
    cmp_count++;
    if (mem_wr.wr&&mem_wr.addr!==w[6:0]) begin
      err_count++;
      $display("wrong value at %0t: addr %h",$time,mem_wr.addr);
    end
    $display("test %h end",w);
  endtask : run
  initial begin
    repeat (3) @(posedge core_clk);
    nrst<=1'b1;
    run(14'h0a85,8'hff,1'b1,19'h40003);
    run(14'h0f5a,8'h00,1'b1,19'h0016b);
    run(14'h0405,8'h21,1'b1,19'h001ed);
    run(14'h0885,8'h00,1'b1,19'h401ef);
    run(14'h0085,8'h33,1'b1,19'h5edef);
    run(14'h0005,8'h44,1'b1,19'h001ef);
    run(14'h0c11,8'h00,1'b0,19'h001ee);
    run(14'h0a05,8'h7f,1'b1,19'h00201);
    run(14'h0805,8'h00,1'b1,19'h00003);
    conclude();
  end
endmodule : file_register_move_inc_or_exec_test
